// ==== bench/slsm_mapper_bench.sv ====
`timescale 1ns/1ps
`include "slsm_defines.svh"

module slsm_mapper_bench;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wr_data_i = 32'h00000000;
    logic wr_strobe_i = 1'b0;
    logic rd_strobe_i = 1'b0;
    logic pd_pin = 1'b0;
    logic samp_valid_i = 1'b1;
    logic rx_fec = 1'b0;
    logic [11:0] s [8];
    logic [14:0] ai = 15'h4321;
    logic [14:0] aq = 15'h1abc;
    logic [14:0] bi = 15'h7f0e;
    logic [14:0] bq = 15'h0f0f;
    logic [3:0] ovr = 4'b1001;
    logic [31:0] rd_data;
    logic [31:0] lane_w [6];
    logic [31:0] lane_exp [6];
    logic [5:0] lane_en;
    logic frame_valid;
    logic fec_en;
    logic crc12_en;
    logic [15:0] rx_frames;
    logic rx_err;
    logic [31:0] v;
    int err_total = 0;
    int num_checks = 0;

    // ----------------------------------------
    // Instances
    // ----------------------------------------
    slsm_mapper dut_u (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
        .wr_strobe_i(wr_strobe_i), .rd_strobe_i(rd_strobe_i), .rd_data_o(rd_data),
        .powerdown_input_i(pd_pin), .samp_valid_i(samp_valid_i),
        .samp_lo_i({s[3], s[2], s[1], s[0]}), .samp_hi_i({s[7], s[6], s[5], s[4]}),
        .chan_a_i_i(ai), .chan_a_q_i(aq), .chan_b_i_i(bi), .chan_b_q_i(bq),
        .chan_a_overrange_0_i(ovr[0]), .chan_a_overrange_1_i(ovr[1]),
        .chan_b_overrange_0_i(ovr[2]), .chan_b_overrange_1_i(ovr[3]),
        .lane_group_a_0_o(lane_w[0]), .lane_group_a_1_o(lane_w[1]),
        .lane_group_a_2_o(lane_w[2]), .lane_group_b_0_o(lane_w[3]),
        .lane_group_b_1_o(lane_w[4]), .lane_group_b_2_o(lane_w[5]),
        .lane_en_o(lane_en), .frame_valid_o(frame_valid), .fec_en_o(fec_en),
        .crc12_en_o(crc12_en));
    slsm_rx_model rx_u (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .lane_en_i(lane_en),
        .frame_valid_i(frame_valid), .fec_en_i(fec_en), .crc12_en_i(crc12_en),
        .fec_cfg_i(rx_fec), .frames_o(rx_frames), .mode_err_o(rx_err));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_strobe_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_strobe_i <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_strobe_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_strobe_i <= 1'b0;
        #1;
        d = rd_data;
    endtask

    // Bounded wait for live frames after a flush
    task automatic wait_live(output int n);
        n = 0;
        while (frame_valid !== 1'b1 && n < 200) begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
    endtask

    // Lane words held in the upper 16 bits, two 48-bit groups
    task automatic fill16(input logic [47:0] ga, input logic [47:0] gb);
        lane_exp = '{{ga[47:32], 16'h0}, {ga[31:16], 16'h0}, {ga[15:0], 16'h0},
                     {gb[47:32], 16'h0}, {gb[31:16], 16'h0}, {gb[15:0], 16'h0}};
    endtask

    task automatic chk_lanes(input logic [5:0] en);
        repeat (3) @(posedge sys_clk_i);
        #1;
        for (int k = 0; k < 6; k++) begin
            chk32($sformatf("lane %0d", k), lane_exp[k], lane_w[k]);
        end
        chk32("lane enables", {26'h0, en}, {26'h0, lane_en});
        chk_bit("frame valid", 1'b1, frame_valid);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_reset();
        rd(`SLSM_ADDR_CFG, v);
        chk32("cfg reset", 32'h00000020, v);
        rd(`SLSM_ADDR_SYNC, v);
        chk32("sync reset", 32'h00000000, v);
        chk_bit("crc12 at reset", 1'b1, crc12_en);
        rd(8'h10, v);
        chk32("unmapped read", 32'h00000000, v);
    endtask

    task automatic test_bypass12();
        wr(`SLSM_ADDR_CFG, 32'h00001020);
        fill16({s[0], s[2], s[4], s[6]}, {s[1], s[3], s[5], s[7]});
        chk_lanes(6'h3f);
        wr(`SLSM_ADDR_CFG, 32'h00001021);
        fill16({s[0], s[1], s[2], s[3]}, {s[4], s[5], s[6], s[7]});
        chk_lanes(6'h3f);
    endtask

    task automatic test_octet8();
        wr(`SLSM_ADDR_CFG, 32'h00001022);
        lane_exp = '{{s[0][11:4], 24'h0}, {s[2][11:4], 24'h0}, 32'h0,
                     {s[1][11:4], 24'h0}, {s[3][11:4], 24'h0}, 32'h0};
        chk_lanes(6'h1b);
        wr(`SLSM_ADDR_CFG, 32'h00001023);
        lane_exp = '{{s[0][11:4], 24'h0}, {s[1][11:4], 24'h0}, 32'h0,
                     {s[4][11:4], 24'h0}, {s[5][11:4], 24'h0}, 32'h0};
        chk_lanes(6'h1b);
    endtask

    task automatic test_decim();
        wr(`SLSM_ADDR_CFG, 32'h00001025);
        lane_exp = '{{ai, ovr[0], 16'h0}, {aq, ovr[1], 16'h0}, 32'h0,
                     {bi, ovr[2], 16'h0}, {bq, ovr[3], 16'h0}, 32'h0};
        chk_lanes(6'h1b);
        wr(`SLSM_ADDR_CFG, 32'h00001026);
        lane_exp = '{{ai, ovr[0], 16'h0}, 32'h0, 32'h0, {aq, ovr[1], 16'h0}, 32'h0, 32'h0};
        chk_lanes(6'h09);
        lane_exp = '{{ai, ovr[0], aq, ovr[1]}, 32'h0, 32'h0, {bi, ovr[2], bq, ovr[3]}, 32'h0,
                     32'h0};
        wr(`SLSM_ADDR_CFG, 32'h00001027);
        chk_lanes(6'h09);
        wr(`SLSM_ADDR_CFG, 32'h00001038);
        chk_lanes(6'h09);
    endtask

    task automatic test_sync();
        wr(`SLSM_ADDR_SYNC, 32'h00000001);
        rx_fec <= 1'b1;
        rd(`SLSM_ADDR_SYNC, v);
        chk32("fec mode", 32'h00000001, v);
        chk_bit("receiver match", 1'b0, rx_err);
        wr(`SLSM_ADDR_SYNC, 32'h00000002);
        rd(`SLSM_ADDR_SYNC, v);
        chk32("short crc refused", 32'h00000001, v);
        wr(`SLSM_ADDR_SYNC, 32'h00000000);
        rx_fec <= 1'b0;
        rd(`SLSM_ADDR_SYNC, v);
        chk_bit("crc12 again", 1'b1, crc12_en);
        chk_bit("receiver match", 1'b0, rx_err);
    endtask

    task automatic test_powerdown();
        int n;
        wr(`SLSM_ADDR_CFG, 32'h00001021);
        @(posedge sys_clk_i);
        pd_pin <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        #1;
        chk32("pin lanes off", 32'h00000000, {26'h0, lane_en});
        chk_bit("pin frame off", 1'b0, frame_valid);
        chk32("pin lane word", 32'h00000000, lane_w[0]);
        @(posedge sys_clk_i);
        pd_pin <= 1'b0;
        wait_live(n);
        chk_bit("flush length", 1'b1, n >= 64 && n <= 72);
        wr(`SLSM_ADDR_CFG, 32'h00001121);
        repeat (3) @(posedge sys_clk_i);
        #1;
        chk32("mode lanes off", 32'h00000000, {26'h0, lane_en});
        wr(`SLSM_ADDR_CFG, 32'h00001021);
        wait_live(n);
        chk_bit("mode flush", 1'b1, n >= 60 && n <= 72);
    endtask

    task automatic test_chan_pd();
        wr(`SLSM_ADDR_CFG, 32'h00001221);
        fill16(48'h0, {s[4], s[5], s[6], s[7]});
        chk_lanes(6'h38);
        wr(`SLSM_ADDR_CFG, 32'h00001421);
        fill16({s[0], s[1], s[2], s[3]}, 48'h0);
        chk_lanes(6'h07);
        wr(`SLSM_ADDR_CFG, 32'h00001220);
        fill16({s[0], s[2], s[4], s[6]}, {s[1], s[3], s[5], s[7]});
        chk_lanes(6'h3f);
    endtask

    // Pattern writes are made with the link off, as the mapper requires; one made with the link up is refused
    task automatic test_pattern();
        wr(`SLSM_ADDR_CFG, 32'h00000022);
        wr(`SLSM_ADDR_TEST, 32'h00000001);
        wr(`SLSM_ADDR_CFG, 32'h00001022);
        lane_exp = '{`SLSM_CLK_PAT, `SLSM_CLK_PAT, 32'h0, `SLSM_CLK_PAT, `SLSM_CLK_PAT, 32'h0};
        chk_lanes(6'h1b);
        wr(`SLSM_ADDR_TEST, 32'h00000004);
        rd(`SLSM_ADDR_TEST, v);
        chk32("test write refused", 32'h00000001, v);
        wr(`SLSM_ADDR_CFG, 32'h00000026);
        wr(`SLSM_ADDR_TEST, 32'h00000004);
        wr(`SLSM_ADDR_CFG, 32'h00001026);
        lane_exp = '{`SLSM_ALT_PAT, 32'h0, 32'h0, `SLSM_ALT_PAT, 32'h0, 32'h0};
        chk_lanes(6'h09);
        wr(`SLSM_ADDR_CFG, 32'h00000022);
        wr(`SLSM_ADDR_TEST, 32'h00000000);
        wr(`SLSM_ADDR_TEST, 32'h00000003);
        wr(`SLSM_ADDR_CFG, 32'h00001022);
        lane_exp = '{32'h0, 32'h01010101, 32'h0, 32'h0, 32'h01010101, 32'h0};
        chk_lanes(6'h1b);
        chk_bit("receiver frames", 1'b1, rx_frames != 16'h0000);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------
    initial begin
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end

    // Whole run is near 260 cycles; 20,000 leaves ample room
    initial begin
        #100000;
        err_total++;
        final_report();
    end

    initial begin
        for (int k = 0; k < 8; k++) begin
            s[k] = 12'h0a5 + 12'h1f3 * 12'(k);
        end
        repeat (8) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        test_reset();
        test_bypass12();
        test_octet8();
        test_decim();
        test_sync();
        test_powerdown();
        test_chan_pd();
        test_pattern();
        final_report();
    end
endmodule

// ==== bench/slsm_rx_model.sv ====
`timescale 1ns/1ps

// Receiver side: counts live frames and flags a sync-header mode mismatch
module slsm_rx_model (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [5:0] lane_en_i,
    input wire logic frame_valid_i,
    input wire logic fec_en_i,
    input wire logic crc12_en_i,
    input wire logic fec_cfg_i,
    output logic [15:0] frames_o,
    output logic mode_err_o
);
    // Converter-off calibration setting is not modelled here
    assign mode_err_o = (fec_en_i != fec_cfg_i) || (crc12_en_i == fec_en_i);

    // stale data ignored
    // Only live frames count, so flushed pipeline contents never reach the user
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            frames_o <= 16'h0000;
        end else if (frame_valid_i && (lane_en_i != 6'h00)) begin
            frames_o <= frames_o + 16'h0001;
        end
    end
endmodule

// ==== shared/slsm_defines.svh ====
`ifndef SLSM_DEFINES_SVH
`define SLSM_DEFINES_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SLSM_ADDR_CFG 8'h00
`define SLSM_ADDR_SYNC 8'h04
`define SLSM_ADDR_TEST 8'h08
`define SLSM_ADDR_STAT 8'h0c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SLSM_CFG_FMT_MSB 5
`define SLSM_CFG_PD_BIT 8
`define SLSM_CFG_PDA_BIT 9
`define SLSM_CFG_PDB_BIT 10
`define SLSM_CFG_LINK_BIT 12

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SLSM_FMT_RST 6'h20
`define SLSM_SYNC_RST 2'h0
`define SLSM_TEST_RST 4'h0

// ----------------------------------------
// Timing and fixed patterns
// ----------------------------------------
`define SLSM_CLK_NS 5
`define SLSM_FLUSH_NS 320
`define SLSM_FLUSH_CYC ((`SLSM_FLUSH_NS + `SLSM_CLK_NS - 1) / `SLSM_CLK_NS)
`define SLSM_CLK_PAT 32'hff00ff00
`define SLSM_ALT_PAT 32'haaaaaaaa
`define SLSM_RAMP_STEP 8'h04

`endif

// ==== shared/slsm_pkg.sv ====
package slsm_pkg;

    // ----------------------------------------
    // Link formats
    // ----------------------------------------
    typedef enum logic [5:0] {
        fmt_b12_single = 6'b100000,
        fmt_b12_dual = 6'b100001,
        fmt_b8_single = 6'b100010,
        fmt_b8_dual = 6'b100011,
        fmt_d4_dual = 6'b100101,
        fmt_d8_single = 6'b100110,
        fmt_d8_dual = 6'b100111,
        fmt_d16_dual = 6'b111000
    } slsm_fmt_type;

    // ----------------------------------------
    // Test patterns and sync header modes
    // ----------------------------------------
    typedef enum logic [3:0] {
        tp_off = 4'b0000,
        tp_clock = 4'b0001,
        tp_ramp = 4'b0010,
        tp_short = 4'b0011,
        tp_alt = 4'b0100
    } slsm_test_type;

    typedef enum logic [1:0] {
        sh_crc12 = 2'b00,
        sh_fec = 2'b01,
        sh_crc3 = 2'b10
    } slsm_sync_type;

endpackage

// ==== src/slsm_lane_pattern.sv ====
`timescale 1ns/1ps
`include "slsm_defines.svh"

module slsm_lane_pattern #(
    parameter logic [7:0] LANE_IDX = 8'h00
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] sel_i,
    input wire logic advance_i,
    output logic [31:0] pattern_o
);

    logic [7:0] ramp_q;
    logic [7:0] ramp_d;
    logic frame_q;
    logic frame_d;
    logic [7:0] short_oct;

    // Sequence restarts whenever patterns are off
    assign ramp_d = (sel_i == slsm_pkg::tp_off) ? 8'h00 :
                    advance_i ? ramp_q + `SLSM_RAMP_STEP : ramp_q;
    assign frame_d = (sel_i == slsm_pkg::tp_off) ? 1'b0 :
                     advance_i ? ~frame_q : frame_q;

    // Pattern state
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ramp_q <= 8'h00;
            frame_q <= 1'b0;
        end else begin
            ramp_q <= ramp_d;
            frame_q <= frame_d;
        end
    end

    // Short transport: lane index, then its complement
    assign short_oct = frame_q ? (8'hff - LANE_IDX) : LANE_IDX;

    // Pattern select, first octet in the top byte
    assign pattern_o =
        (sel_i == slsm_pkg::tp_clock) ? `SLSM_CLK_PAT :
        (sel_i == slsm_pkg::tp_ramp) ? {ramp_q, ramp_q + 8'h01, ramp_q + 8'h02, ramp_q + 8'h03} :
        (sel_i == slsm_pkg::tp_short) ? {4{short_oct}} :
        (sel_i == slsm_pkg::tp_alt) ? `SLSM_ALT_PAT : 32'h0000_0000;

endmodule

// ==== src/slsm_mapper.sv ====
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "slsm_defines.svh"

// Notes on behaviour
// - 12-bit single: even samples to group A, odd to B, MSB first.
// - 12-bit dual: four A samples on A0..A2, four B on B0..B2.
// - 8-bit single: S0,S2 on A0,A1; S1,S3 on B0,B1; one per octet.
// - 8-bit dual: two A samples on A0,A1; two B samples on B0,B1.
// - Decimate-by-4 dual: AI, AQ, BI, BQ words on A0, A1, B0, B1.
// - Decimate-by-8 single: I word on A0, Q word on B0.
// - Dual decimate-by-8/16: A I then Q on A0; B I then Q on B0.
// - Only CRC-12 checking is offered; the 3-bit variant is refused.
// - Sync header mode picks CRC or FEC; receiver must match it.
// - Pin or mode field power-down turns every lane off and drops frame valid.
// - In dual formats one channel may be powered down alone.
// - Power-down pin high disables every lane driver.
// - Selected test pattern replaces normal lane data.
// - Lane count follows the link format, whatever test pattern runs.
module slsm_mapper (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wr_data_i,
    input wire logic wr_strobe_i,
    input wire logic rd_strobe_i,
    output logic [31:0] rd_data_o,
    input wire logic powerdown_input_i,
    input wire logic samp_valid_i,
    input wire logic [47:0] samp_lo_i,
    input wire logic [47:0] samp_hi_i,
    input wire logic [14:0] chan_a_i_i,
    input wire logic [14:0] chan_a_q_i,
    input wire logic [14:0] chan_b_i_i,
    input wire logic [14:0] chan_b_q_i,
    input wire logic chan_a_overrange_0_i,
    input wire logic chan_a_overrange_1_i,
    input wire logic chan_b_overrange_0_i,
    input wire logic chan_b_overrange_1_i,
    output logic [31:0] lane_group_a_0_o,
    output logic [31:0] lane_group_a_1_o,
    output logic [31:0] lane_group_a_2_o,
    output logic [31:0] lane_group_b_0_o,
    output logic [31:0] lane_group_b_1_o,
    output logic [31:0] lane_group_b_2_o,
    output logic [5:0] lane_en_o,
    output logic frame_valid_o,
    output logic fec_en_o,
    output logic crc12_en_o
);

    // ----------------------------------------
    // Registers and pin synchroniser
    // ----------------------------------------
    logic [5:0] fmt_q;
    logic mode_pd_q;
    logic pda_q;
    logic pdb_q;
    logic link_en_q;
    logic [1:0] sync_q;
    logic [3:0] test_q;
    logic pd_s1_q;
    logic pd_s2_q;
    logic [7:0] flush_q;
    logic [7:0] flush_d;
    logic [31:0] rd_data_q;
    logic [31:0] lane_q [6];
    logic [5:0] lane_en_q;
    logic frame_valid_q;
    logic fec_q;
    logic crc12_q;

    wire wr_cfg = wr_strobe_i && (addr_i == `SLSM_ADDR_CFG);
    wire wr_sync = wr_strobe_i && (addr_i == `SLSM_ADDR_SYNC);
    wire wr_test = wr_strobe_i && (addr_i == `SLSM_ADDR_TEST);
    wire sync_ok = (wr_data_i[1:0] == slsm_pkg::sh_crc12) || (wr_data_i[1:0] == slsm_pkg::sh_fec);
    wire test_ok = !link_en_q;

    // Software-written configuration
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            fmt_q <= `SLSM_FMT_RST;
            mode_pd_q <= 1'b0;
            pda_q <= 1'b0;
            pdb_q <= 1'b0;
            link_en_q <= 1'b0;
        end else if (wr_cfg) begin
            fmt_q <= wr_data_i[`SLSM_CFG_FMT_MSB:0];
            mode_pd_q <= wr_data_i[`SLSM_CFG_PD_BIT];
            pda_q <= wr_data_i[`SLSM_CFG_PDA_BIT];
            pdb_q <= wr_data_i[`SLSM_CFG_PDB_BIT];
            link_en_q <= wr_data_i[`SLSM_CFG_LINK_BIT];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            sync_q <= `SLSM_SYNC_RST;
            test_q <= `SLSM_TEST_RST;
        end else begin
            if (wr_sync && sync_ok) begin
                sync_q <= wr_data_i[1:0];
            end
            if (wr_test && test_ok) begin
                test_q <= wr_data_i[3:0];
            end
        end
    end

    // Pin is asynchronous to the core clock
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pd_s1_q <= 1'b0;
            pd_s2_q <= 1'b0;
        end else begin
            pd_s1_q <= powerdown_input_i;
            pd_s2_q <= pd_s1_q;
        end
    end

    // ----------------------------------------
    // Power-down and pipeline flush
    // ----------------------------------------
    // Pin or mode field
    wire pd_any = pd_s2_q || mode_pd_q;
    wire flush_busy = (flush_q != 8'h00);
    // Hold off data until stale samples drain
    assign flush_d = pd_any ? 8'(`SLSM_FLUSH_CYC) : flush_busy ? flush_q - 8'h01 : 8'h00;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            flush_q <= 8'h00;
        end else begin
            flush_q <= flush_d;
        end
    end

    // ----------------------------------------
    // Format decode and lane enables
    // ----------------------------------------
    wire is_b12 = (fmt_q == slsm_pkg::fmt_b12_single) || (fmt_q == slsm_pkg::fmt_b12_dual);
    wire is_b8 = (fmt_q == slsm_pkg::fmt_b8_single) || (fmt_q == slsm_pkg::fmt_b8_dual);
    wire is_d4 = (fmt_q == slsm_pkg::fmt_d4_dual);
    wire is_d8s = (fmt_q == slsm_pkg::fmt_d8_single);
    wire is_d2 = (fmt_q == slsm_pkg::fmt_d8_dual) || (fmt_q == slsm_pkg::fmt_d16_dual);
    wire dual = (fmt_q == slsm_pkg::fmt_b12_dual) || (fmt_q == slsm_pkg::fmt_b8_dual)
        || is_d4 || is_d2;
    // Lanes from format only, never from the pattern
    wire [5:0] lanes_need = is_b12 ? 6'h3f : (is_b8 || is_d4) ? 6'h1b :
        (is_d8s || is_d2) ? 6'h09 : 6'h00;
    // One channel off in dual formats
    wire pd_a = dual && pda_q;
    wire pd_b = dual && pdb_q;
    wire [5:0] chan_mask = {pd_b ? 3'h0 : 3'h7, pd_a ? 3'h0 : 3'h7};
    wire [5:0] lane_en_d = pd_any ? 6'h00 : (lanes_need & chan_mask);
    wire live = samp_valid_i && link_en_q && !pd_any && !flush_busy;

    // ----------------------------------------
    // Sample mapping
    // ----------------------------------------
    wire [47:0] lo = pd_a ? 48'h0 : samp_lo_i;
    wire [47:0] hi = pd_b ? 48'h0 : samp_hi_i;
    wire [11:0] lo0 = lo[11:0];
    wire [11:0] lo1 = lo[23:12];
    wire [11:0] lo2 = lo[35:24];
    wire [11:0] lo3 = lo[47:36];
    wire [11:0] hi0 = hi[11:0];
    wire [11:0] hi1 = hi[23:12];
    wire [11:0] hi2 = hi[35:24];
    wire [11:0] hi3 = hi[47:36];
    // Single: S0..S3 on low port, S4..S7 on high; evens to A
    // Dual: channel A whole on A lanes, B on B lanes
    wire [47:0] grp_a = dual ? {lo0, lo1, lo2, lo3} : {lo0, lo2, hi0, hi2};
    wire [47:0] grp_b = dual ? {hi0, hi1, hi2, hi3} : {lo1, lo3, hi1, hi3};
    // Top octet of each sample, one per lane octet
    wire [7:0] oct_a0 = lo0[11:4];
    wire [7:0] oct_a1 = dual ? lo1[11:4] : lo2[11:4];
    wire [7:0] oct_b0 = dual ? hi0[11:4] : lo1[11:4];
    wire [7:0] oct_b1 = dual ? hi1[11:4] : lo3[11:4];
    // Value above, overrange in bit 0
    wire [15:0] w_ai = pd_a ? 16'h0 : {chan_a_i_i, chan_a_overrange_0_i};
    wire [15:0] w_aq = pd_a ? 16'h0 : {chan_a_q_i, chan_a_overrange_1_i};
    wire [15:0] w_bi = pd_b ? 16'h0 : {chan_b_i_i, chan_b_overrange_0_i};
    wire [15:0] w_bq = pd_b ? 16'h0 : {chan_b_q_i, chan_b_overrange_1_i};

    // Mapped lane words for every format, first octet on top
    logic [31:0] map_w [6];
    assign map_w[0] = is_b12 ? {grp_a[47:32], 16'h0} : is_b8 ? {oct_a0, 24'h0} :
        is_d2 ? {w_ai, w_aq} : (is_d4 || is_d8s) ? {w_ai, 16'h0} : 32'h0;
    assign map_w[1] = is_b12 ? {grp_a[31:16], 16'h0} : is_b8 ? {oct_a1, 24'h0} :
        is_d4 ? {w_aq, 16'h0} : 32'h0;
    assign map_w[2] = is_b12 ? {grp_a[15:0], 16'h0} : 32'h0;
    assign map_w[3] = is_b12 ? {grp_b[47:32], 16'h0} : is_b8 ? {oct_b0, 24'h0} :
        is_d2 ? {w_bi, w_bq} : is_d4 ? {w_bi, 16'h0} : is_d8s ? {w_aq, 16'h0} : 32'h0;
    assign map_w[4] = is_b12 ? {grp_b[31:16], 16'h0} : is_b8 ? {oct_b1, 24'h0} :
        is_d4 ? {w_bq, 16'h0} : 32'h0;
    assign map_w[5] = is_b12 ? {grp_b[15:0], 16'h0} : 32'h0;

    // ----------------------------------------
    // Test pattern insertion and lane registers
    // ----------------------------------------
    logic [31:0] pat_w [6];
    wire tp_active = (test_q != slsm_pkg::tp_off);

    // One generator per lane; B lanes repeat A's index
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_lane
            slsm_lane_pattern #(
                .LANE_IDX(8'(gi % 3))
            ) u_pat (
                .sys_clk_i(sys_clk_i),
                .rst_n_i(rst_n_i),
                .sel_i(test_q),
                .advance_i(live),
                .pattern_o(pat_w[gi])
            );

            // Pattern replaces data; idle lanes send zero
            wire [31:0] lane_d = !lane_en_d[gi] ? 32'h0 : tp_active ? pat_w[gi] : map_w[gi];

            always_ff @(posedge sys_clk_i) begin
                if (!rst_n_i) begin
                    lane_q[gi] <= 32'h0;
                end else begin
                    lane_q[gi] <= lane_d;
                end
            end
        end
    endgenerate

    // Status toward the link layer
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            lane_en_q <= 6'h00;
            frame_valid_q <= 1'b0;
            fec_q <= 1'b0;
            crc12_q <= 1'b1;
        end else begin
            lane_en_q <= lane_en_d;
            frame_valid_q <= live;
            fec_q <= (sync_q == slsm_pkg::sh_fec);
            crc12_q <= (sync_q != slsm_pkg::sh_fec);
        end
    end

    // ----------------------------------------
    // Register read port
    // ----------------------------------------
    wire [31:0] cfg_rd = {19'h0, link_en_q, 1'b0, pdb_q, pda_q, mode_pd_q, 2'h0, fmt_q};
    wire [31:0] stat_rd = {21'h0, fec_q, flush_busy, pd_any, 2'h0, lane_en_q};
    // Unmapped offsets read zero
    wire [31:0] rd_mux = (addr_i == `SLSM_ADDR_CFG) ? cfg_rd :
        (addr_i == `SLSM_ADDR_SYNC) ? {30'h0, sync_q} :
        (addr_i == `SLSM_ADDR_TEST) ? {28'h0, test_q} :
        (addr_i == `SLSM_ADDR_STAT) ? stat_rd : 32'h0;

    // Data only in the cycle after the strobe
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rd_data_q <= 32'h0;
        end else begin
            rd_data_q <= rd_strobe_i ? rd_mux : 32'h0;
        end
    end

    assign rd_data_o = rd_data_q;
    assign lane_group_a_0_o = lane_q[0];
    assign lane_group_a_1_o = lane_q[1];
    assign lane_group_a_2_o = lane_q[2];
    assign lane_group_b_0_o = lane_q[3];
    assign lane_group_b_1_o = lane_q[4];
    assign lane_group_b_2_o = lane_q[5];
    assign lane_en_o = lane_en_q;
    assign frame_valid_o = frame_valid_q;
    assign fec_en_o = fec_q;
    assign crc12_en_o = crc12_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    wire norm = !tp_active && !pd_a && !pd_b && !pd_any;
    single_even_a: assert property (norm && fmt_q == slsm_pkg::fmt_b12_single
        |=> lane_group_b_0_o[31:20] == $past(samp_lo_i[23:12])
        && lane_group_a_1_o[31:16] == {$past(samp_lo_i[31:24]), $past(samp_hi_i[11:4])})
        else $error("single bypass packing wrong");
    dual_pack_a: assert property (norm && fmt_q == slsm_pkg::fmt_b12_dual
        |=> lane_group_b_2_o[31:16] == {$past(samp_hi_i[27:24]), $past(samp_hi_i[47:36])})
        else $error("dual bypass packing wrong");
    byte_single_a: assert property (norm && fmt_q == slsm_pkg::fmt_b8_single
        |=> lane_group_b_0_o == {$past(samp_lo_i[23:16]), 24'h0})
        else $error("8-bit single lane wrong");
    byte_dual_a: assert property (norm && fmt_q == slsm_pkg::fmt_b8_dual
        |=> lane_group_b_1_o[31:24] == $past(samp_hi_i[23:16]))
        else $error("8-bit dual lane wrong");
    dec4_word_a: assert property (norm && is_d4
        |=> lane_group_a_1_o == {$past(chan_a_q_i), $past(chan_a_overrange_1_i), 16'h0})
        else $error("decimate-by-4 word wrong");
    dec8_single_a: assert property (norm && is_d8s
        |=> lane_group_b_0_o == {$past(chan_a_q_i), $past(chan_a_overrange_1_i), 16'h0})
        else $error("decimate-by-8 single wrong");
    dec_frame_a: assert property (norm && is_d2
        |=> lane_group_b_0_o[15:0] == {$past(chan_b_q_i), $past(chan_b_overrange_1_i)})
        else $error("four-octet frame wrong");
    crc_only_a: assert property (sync_q != slsm_pkg::sh_crc3 && crc12_en_o == !fec_en_o)
        else $error("CRC-3 mode reached");
    sync_mode_a: assert property (wr_sync && wr_data_i[1:0] == slsm_pkg::sh_fec
        |-> ##2 fec_en_o && !crc12_en_o)
        else $error("FEC select not applied");
    mode_pd_a: assert property (mode_pd_q |=> lane_en_o == 6'h00 && !frame_valid_o)
        else $error("mode power-down ignored");
    chan_pd_a: assert property (dual && pdb_q && !pda_q && !pd_any
        |=> lane_en_o[5:3] == 3'h0 && lane_en_o[0])
        else $error("channel power-down wrong");
    pin_pd_a: assert property (powerdown_input_i [*3] |=> lane_en_o == 6'h00)
        else $error("lanes driven during power-down");
    flush_hold_a: assert property ($fell(pd_any) |-> !frame_valid_o [*8])
        else $error("stale data released early");
    pattern_in_a: assert property (test_q == slsm_pkg::tp_clock && lane_en_d[0]
        |=> lane_group_a_0_o == `SLSM_CLK_PAT)
        else $error("test pattern not inserted");
    lanes_fmt_a: assert property (tp_active && !pd_any && !dual
        |=> lane_en_o == $past(lanes_need))
        else $error("lane count follows pattern");
    test_lock_a: assert property (link_en_q && $past(link_en_q) |-> $stable(test_q))
        else $error("pattern changed with link up");
    cover_bypass_c: cover property (live && fmt_q == slsm_pkg::fmt_b12_single ##1 frame_valid_o);
    cover_fec_c: cover property (fec_en_o && live && is_d2);
    cover_pd_exit_c: cover property ($fell(pd_any) ##[1:100] frame_valid_o);
    cover_ramp_c: cover property (test_q == slsm_pkg::tp_ramp && live [*4]);

endmodule
